/* File: verif/load_plant.sv */
`default_nettype none
// Load and die model: comparators report the load as it is, one clock
// late; gating by the command is left to the device
module load_plant
    import channel_diagnostic_register_pkg::*;
(
    input wire logic hclk,
    input wire logic [CHANNELS-1:0] hot,
    input wire logic [CHANNELS-1:0] overload,
    input wire logic [CHANNELS-1:0] open_ld,
    output sense_s [CHANNELS-1:0] sense
);
    // Comparator path register
    always_ff @(posedge hclk) begin
        for (int i = 0; i < CHANNELS; i++) begin
            sense[i] <= {hot[i], overload[i], open_ld[i]};
        end
    end
endmodule
`default_nettype wire

/* File: verif/sfd_properties.sv */
`default_nettype none
// Pin-level watch on the diagnostic block
module sfd_properties
    import channel_diagnostic_register_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [CHANNELS-1:0] channel_input_pin,
    input wire sense_s [CHANNELS-1:0] sense,
    input wire drive_s [CHANNELS-1:0] drive,
    input wire logic fault_indicator_n_o,
    input wire logic fault_indicator_n_oe,
    input wire logic open_channel_indicator_n_o,
    input wire logic open_channel_indicator_n_oe
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic [7:0] run [CHANNELS][3]; // Held-high run: 0 open, 1 oc, 2 hot
    logic [2:0] long; // Kinds held almost as long as the filter on some channel
    logic all_hot; // Every channel hot long enough to act on
    // Runs saturate so a lasting fault never wraps to look brief
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < CHANNELS; i++) begin
                for (int k = 0; k < 3; k++) begin
                    run[i][k] <= 8'h0;
                end
            end
        end else begin
            for (int i = 0; i < CHANNELS; i++) begin
                for (int k = 0; k < 3; k++) begin
                    if (!sense[i][k]) begin
                        run[i][k] <= 8'h0;
                    end else if (run[i][k] != 8'hff) begin
                        run[i][k] <= run[i][k] + 8'h1;
                    end
                end
            end
        end
    end
    // 95 is just short of the filter; 105 leaves room for its extra edge
    always_comb begin
        long = 3'h0;
        all_hot = 1'b1;
        for (int i = 0; i < CHANNELS; i++) begin
            for (int k = 0; k < 3; k++) begin
                long[k] = long[k] | (run[i][k] >= 8'h5f);
            end
            all_hot = all_hot & (run[i][2] >= 8'h69);
        end
    end
    sequence fault_rise;
        $rose(fault_indicator_n_oe);
    endsequence
    sequence open_rise;
        $rose(open_channel_indicator_n_oe);
    endsequence
    sequence all_on;
        (&channel_input_pin) [*4];
    endsequence
    chk_fault_filtered: assert property (fault_rise |-> |long)
        else $error("fault pin rose without a lasting condition");
    chk_open_filtered: assert property (open_rise |-> long[0])
        else $error("open pin rose without a lasting open load");
    chk_open_gated: assert property (
        all_on |-> !open_channel_indicator_n_oe)
        else $error("open pin active on a commanded channel");
    chk_all_hot_off: assert property (all_hot |-> drive == 8'h55)
        else $error("hot die left a switch on or clamp high");
    chk_drain_low: assert property (
        !fault_indicator_n_o && !open_channel_indicator_n_o)
        else $error("indicator drives high");
    for (genvar g = 0; g < CHANNELS; g++) begin : per_chan
        chk_hot_fault: assert property (
            run[g][2] >= 8'h69 |-> fault_indicator_n_oe)
            else $error("hot channel without fault pin");
        chk_hot_drive_safe: assert property (
            run[g][2] >= 8'h69 |-> !drive[g].switch_on && drive[g].low_clamp)
            else $error("hot channel not held off at low clamp");
        chk_oc_switch_off: assert property (
            run[g][1] >= 8'h69 |-> !drive[g].switch_on)
            else $error("overloaded channel left on");
    end
endmodule
bind switch_fault_diagnostics sfd_properties chk_u (.hclk(hclk),
    .hresetn(hresetn), .channel_input_pin(channel_input_pin),
    .sense(sense), .drive(drive), .fault_indicator_n_o(fault_indicator_n_o),
    .fault_indicator_n_oe(fault_indicator_n_oe),
    .open_channel_indicator_n_o(open_channel_indicator_n_o),
    .open_channel_indicator_n_oe(open_channel_indicator_n_oe));
`default_nettype wire

/* File: verif/tb_top.sv */
`default_nettype none
module tb_top
    import channel_diagnostic_register_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
    logic [11:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, rd; // rd: last word read
    logic [3:0] pin, hot, overload, open_ld; // Commands and load state
    sense_s [CHANNELS-1:0] sense;
    drive_s [CHANNELS-1:0] drive;
    logic flt_o, flt_oe, opn_o, opn_oe;
    int errors, checks, cycles, c;
    // Lone slave: its hreadyout is the bus hready
    switch_fault_diagnostics dut_u (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .channel_input_pin(pin), .sense(sense), .drive(drive),
        .fault_indicator_n_o(flt_o), .fault_indicator_n_oe(flt_oe),
        .open_channel_indicator_n_o(opn_o),
        .open_channel_indicator_n_oe(opn_oe), .irq(irq));
    load_plant plant_u (.hclk(hclk), .hot(hot), .overload(overload),
        .open_ld(open_ld), .sense(sense));
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    // The run needs a few thousand cycles; a hang is cut far beyond that
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            test_done;
        end
    end
    task automatic test_done;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask
    // Single AHB word: address held until hready, then the data phase
    task automatic xfer(input logic w, input logic [11:0] a,
            input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        // Read word is taken at the very edge that ends the data phase
        rd = hrdata;
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(exp, rd);
        chk(32'h0, {31'h0, hresp}); // Response is always OKAY
    endtask
    // Filter needs 100 steady clocks; 120 covers it and the flag edge
    task automatic settle;
        repeat (120) @(posedge hclk);
    endtask
    function automatic logic [11:0] chan_addr(int ch);
        return (ch < 2) ? CHANNEL_SUMMARY_FLAG_LO_ADDR : CHANNEL_SUMMARY_FLAG_HI_ADDR;
    endfunction
    // Flag position within the channel pair word
    function automatic logic [31:0] flag(int ch, int b);
        return 32'h1 << (b + NIBBLE * (ch % 2));
    endfunction
    initial begin
        {hresetn, hsel, hwrite, haddr, htrans, hwdata} = '0;
        hsize = 3'b010;
        {pin, hot, overload, open_ld} = '0;
        c = $urandom(32'h66fed018);
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        // Reset values; an unmapped word ignores writes and reads zero
        xfer(1'b1, 12'h030, $urandom);
        rdchk(12'h030, 32'h0);
        rdchk(AUTO_CLEAR_ADDR, {28'h0, AUTO_CLEAR_RESET});
        rdchk(FAULT_SELECT_ADDR, {28'h0, FAULT_SELECT_RESET});
        rdchk(IRQ_MASK_ADDR, {28'h0, IRQ_MASK_RESET});
        rdchk(TOP_CHANNEL_DIAGNOSTIC_REGISTER_ADDR, 32'h0);
        $display("test reset done");
        // One hot channel, other channels commanded at random
        c = $urandom_range(3);
        pin <= 4'($urandom);
        hot[c] <= 1'b1;
        settle;
        rdchk(chan_addr(c), flag(c, OT_BIT));
        rdchk(TOP_CHANNEL_DIAGNOSTIC_REGISTER_ADDR, 32'h1 << c);
        chk(32'h3, {29'h0, drive[c].switch_on, drive[c].low_clamp, flt_oe});
        hot[c] <= 1'b0;
        settle;
        rdchk(chan_addr(c), 32'h0);
        // Excursion shorter than the filter is never reported
        hot[c] <= 1'b1;
        repeat ($urandom_range(90, 1)) @(posedge hclk);
        hot[c] <= 1'b0;
        settle;
        rdchk(TOP_CHANNEL_DIAGNOSTIC_REGISTER_ADDR, 32'h0);
        chk(32'h0, {31'h0, flt_oe});
        $display("test hot channel done");
        // Whole die hot: shutdown bit over every summary bit
        hot <= 4'hf;
        settle;
        rdchk(TOP_CHANNEL_DIAGNOSTIC_REGISTER_ADDR, (32'h1 << TOP_SHUTDOWN_BIT) | 32'hf);
        chk(32'h55, {24'h0, drive});
        {hot, pin} <= 8'h0;
        settle;
        $display("test all hot done");
        // Enable bit n commands channel n+1, then overload on the pin
        c = $urandom_range(3);
        xfer(1'b1, SWITCH_ENABLE_ADDR, 32'h1 << c);
        rdchk(SWITCH_ENABLE_ADDR, 32'h1 << c);
        chk(32'h1, {31'h0, drive[c].switch_on});
        rdchk(SWITCH_STATUS_ADDR, 32'h1 << c);
        xfer(1'b1, SWITCH_ENABLE_ADDR, 32'h0);
        pin[c] <= 1'b1;
        overload[c] <= 1'b1;
        settle;
        rdchk(chan_addr(c), flag(c, OC_BIT));
        chk(32'h1, {30'h0, drive[c].switch_on, flt_oe});
        pin[c] <= 1'b0;
        settle;
        rdchk(chan_addr(c), 32'h0);
        overload[c] <= 1'b0;
        $display("test overcurrent done");
        // Open load reported only while the channel is off
        open_ld[c] <= 1'b1;
        settle;
        rdchk(chan_addr(c), flag(c, OPEN_BIT));
        chk(32'h2, {30'h0, opn_oe, flt_oe});
        pin <= 4'hf; // Every channel on, so the all-on watch is exercised
        repeat (5) @(posedge hclk);
        chk(32'h0, {31'h0, opn_oe});
        rdchk(chan_addr(c), 32'h0);
        // Host routes open load onto the fault pin
        xfer(1'b1, FAULT_SELECT_ADDR, 32'h1 << KIND_OPEN);
        pin[c] <= 1'b0;
        settle;
        chk(32'h3, {30'h0, opn_oe, flt_oe});
        open_ld[c] <= 1'b0;
        xfer(1'b1, FAULT_SELECT_ADDR, {28'h0, FAULT_SELECT_RESET});
        settle;
        $display("test open load done");
        // Held report outlives the heat until cleared; live one returns
        xfer(1'b1, AUTO_CLEAR_ADDR, 32'h0);
        hot[c] <= 1'b1;
        settle;
        hot[c] <= 1'b0;
        settle;
        rdchk(chan_addr(c), flag(c, OT_BIT));
        xfer(1'b1, CLEAR_REPORT_ADDR, 32'h1 << KIND_OT);
        rdchk(chan_addr(c), 32'h0);
        hot[c] <= 1'b1;
        settle;
        xfer(1'b1, CLEAR_REPORT_ADDR, 32'h1 << KIND_OT);
        rdchk(chan_addr(c), flag(c, OT_BIT));
        hot[c] <= 1'b0;
        settle;
        xfer(1'b1, CLEAR_REPORT_ADDR, 32'hf);
        xfer(1'b1, AUTO_CLEAR_ADDR, {28'h0, AUTO_CLEAR_RESET});
        $display("test held report done");
        // Interrupt: masked, unmasked, then cleared by writing one
        xfer(1'b1, IRQ_STATUS_ADDR, 32'hf);
        hot[c] <= 1'b1;
        settle;
        rdchk(IRQ_STATUS_ADDR, 32'h1 << KIND_OT);
        chk(32'h0, {31'h0, irq});
        xfer(1'b1, IRQ_MASK_ADDR, 32'h1 << KIND_OT);
        hot[c] <= 1'b0;
        settle;
        chk(32'h1, {31'h0, irq});
        xfer(1'b1, IRQ_STATUS_ADDR, 32'h1 << KIND_OT);
        repeat (2) @(posedge hclk);
        chk(32'h0, {31'h0, irq});
        $display("test interrupt done");
        test_done;
    end
endmodule
`default_nettype wire

/* File: verilog/channel_diagnostic_register_pkg.sv */
`default_nettype none
package channel_diagnostic_register_pkg;
    localparam int CHANNELS = 4;
    localparam int CHANNEL_DIAGNOSTIC_REGISTER_KINDS = 3;
    // Register byte addresses on the bus
    localparam logic [11:0] TOP_CHANNEL_DIAGNOSTIC_REGISTER_ADDR = 12'h000;
    localparam logic [11:0] CHANNEL_SUMMARY_FLAG_LO_ADDR = 12'h004;
    localparam logic [11:0] CHANNEL_SUMMARY_FLAG_HI_ADDR = 12'h008;
    localparam logic [11:0] SWITCH_ENABLE_ADDR = 12'h00c;
    localparam logic [11:0] AUTO_CLEAR_ADDR = 12'h010;
    localparam logic [11:0] CLEAR_REPORT_ADDR = 12'h014;
    localparam logic [11:0] FAULT_SELECT_ADDR = 12'h018;
    localparam logic [11:0] IRQ_STATUS_ADDR = 12'h01c;
    localparam logic [11:0] IRQ_MASK_ADDR = 12'h020;
    localparam logic [11:0] SWITCH_STATUS_ADDR = 12'h024;
    // Field positions
    localparam int TOP_SHUTDOWN_BIT = 6;
    localparam int OC_BIT = 3;
    localparam int OT_BIT = 1;
    localparam int OPEN_BIT = 0;
    localparam int NIBBLE = 4;
    // Diagnostic kind index: 0 open-load, 1 over-temp, 2 over-current, 3 shut
    localparam int KIND_OPEN = 0;
    localparam int KIND_OT = 1;
    localparam int KIND_OC = 2;
    localparam int KIND_SD = 3;
    // Reset values
    localparam logic [3:0] AUTO_CLEAR_RESET = 4'hf;
    localparam logic [3:0] FAULT_SELECT_RESET = 4'he;
    localparam logic [3:0] SWITCH_ENABLE_RESET = 4'h0;
    localparam logic [3:0] IRQ_MASK_RESET = 4'h0;
    // Persistence filter: samples a level must hold before it is believed
    localparam int FILTER_TIME_NS = 1000;
    localparam int CLOCK_PERIOD_NS = 10;
    localparam int FILTER_CYCLES = (FILTER_TIME_NS + CLOCK_PERIOD_NS - 1)
        / CLOCK_PERIOD_NS;
    localparam int FILTER_W = $clog2(FILTER_CYCLES + 1);
    // Analog comparator outputs for one channel
    typedef struct packed {
        logic over_temp;
        logic over_current;
        logic open_load;
    } sense_s;
    // Drive results for one channel
    typedef struct packed {
        logic switch_on;
        logic low_clamp;
    } drive_s;
endpackage
`default_nettype wire

/* File: verilog/persist_filter.sv */
`default_nettype none
// Passes a level only after it has held steady for FILTER_CYCLES clocks
module persist_filter
    import channel_diagnostic_register_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic raw,
    output logic filtered
);
    logic [FILTER_W-1:0] count; // Cycles the new level has held
    logic [FILTER_W-1:0] next_count;
    logic next_filtered;

    // Restart the count whenever the raw level flips back
    always_comb begin
        next_count = '0;
        next_filtered = filtered;
        if (raw != filtered) begin
            if (count == FILTER_W'(FILTER_CYCLES - 1)) begin
                next_filtered = raw; // R03
            end else begin
                next_count = count + 1'b1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count <= '0;
            filtered <= 1'b0;
        end else begin
            count <= next_count;
            filtered <= next_filtered;
        end
    end
endmodule
`default_nettype wire

/* File: verilog/switch_fault_diagnostics.sv */
// What this block does
// R01: Hot channel: flag, fault, switch off, low clamp
// R02: All hot: shutdown flag, all off, low clamps
// R03: Brief temperature excursions leave reports unchanged
// R04: On and overcurrent: flag, fault, switch off
// R05: Off and open load: flag, open indicator
// R06: Open load measured only while channel off
// R07: Enable bit 0 drives channel one
// R08: Indicators active low, open drain
// R09: Host selects which diagnostics drive fault
// R10: Non-auto-clear reports held until host clears, open load only while off and overcurrent only while on
// R11: Clearing live condition regenerates report at once
// R12: Top register bit 6 is all-channel shutdown
// R13: Channel pair register nibble layout fixed
// R14: Summary flag set when channel has any flag
//
// The AHB-Lite slave port and the address map are this design's own decisions.
`default_nettype none
module switch_fault_diagnostics
    import channel_diagnostic_register_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [CHANNELS-1:0] channel_input_pin,
    input wire sense_s [CHANNELS-1:0] sense,
    output drive_s [CHANNELS-1:0] drive,
    output logic fault_indicator_n_o,
    output logic fault_indicator_n_oe,
    output logic open_channel_indicator_n_o,
    output logic open_channel_indicator_n_oe,
    output logic irq
);
    // Filtered comparator levels
    logic [CHANNELS-1:0] hot;
    logic [CHANNELS-1:0] over_cur;
    logic [CHANNELS-1:0] open_ld;
    // Commanded state: pin or register enable
    logic [CHANNELS-1:0] switch_enable_bits;
    logic [CHANNELS-1:0] commanded;
    // Live conditions per kind, per channel
    logic [CHANNELS-1:0] live_open, live_ot, live_oc;
    logic live_sd;
    // Held reports
    logic [CHANNELS-1:0] channel_open_load_warning;
    logic [CHANNELS-1:0] channel_overtemp_constraint;
    logic [CHANNELS-1:0] channel_overcurrent_shutdown;
    logic all_channel_overtemp_shutdown;
    logic [CHANNELS-1:0] channel_summary_flag;
    // Software registers
    logic [3:0] auto_clear_mask; // One bit per diagnostic kind
    logic [3:0] fault_select;    // Kinds that pull the fault pin
    logic [3:0] irq_status;
    logic [3:0] irq_mask;
    // Bus data-phase capture
    logic wr_pend, rd_pend;
    logic [11:0] addr_q;
    logic [31:0] rdata_c;
    logic bus_go;
    // Next values
    logic [CHANNELS-1:0] next_open, next_ot, next_oc;
    logic next_sd;
    logic [3:0] clr;
    logic [3:0] next_auto, next_fsel, next_irq_status, next_irq_mask;
    logic [CHANNELS-1:0] next_switch_enable_bits;
    // Per-kind rise of a report, feeds the interrupt status
    logic [3:0] kind_event;
    logic [3:0] kind_any;
    drive_s [CHANNELS-1:0] next_drive;
    logic next_fault_oe, next_open_oe, next_irq;
    logic [31:0] next_hrdata;

    // One filter per comparator per channel so glitches never reach reports
    // Separate filters per kind cost area but keep their timing apart
    genvar g;
    generate
        for (g = 0; g < CHANNELS; g++) begin : g_ch
            persist_filter u_ot (
                .hclk(hclk), .hresetn(hresetn),
                .raw(sense[g].over_temp), .filtered(hot[g])
            ); // R03
            persist_filter u_oc (
                .hclk(hclk), .hresetn(hresetn),
                .raw(sense[g].over_current), .filtered(over_cur[g])
            );
            persist_filter u_ol (
                .hclk(hclk), .hresetn(hresetn),
                .raw(sense[g].open_load), .filtered(open_ld[g])
            );
        end
    endgenerate

    // Live conditions; bit n of the enable drives channel n+1
    always_comb begin
        commanded = channel_input_pin | switch_enable_bits; // R07
        // Shutdown needs every channel hot; one cool channel keeps it off
        live_sd = &hot; // R02
        live_ot = hot; // R01
        live_oc = commanded & over_cur; // R04
        // Load resistance only means something while the channel is off
        live_open = ~commanded & open_ld; // R05 R06
    end

    // Taken when selected, ready and neither idle nor busy
    assign bus_go = hsel && hready && htrans[1];
    // Writes of one to the clear register drop held reports
    assign clr = (wr_pend && addr_q == CLEAR_REPORT_ADDR) ?
        hwdata[3:0] : 4'h0;

    // Report holding: set wins, auto-clear follows, else hold until cleared (open load while off, overcurrent while on)
    always_comb begin
        next_open = live_open; // R06
        next_ot = live_ot;
        next_oc = live_oc;
        next_sd = live_sd;
        if (!auto_clear_mask[KIND_OPEN]) begin
            // Off channels only: a report may not persist once switched on
            next_open = live_open | (channel_open_load_warning
                & ~commanded & {CHANNELS{~clr[KIND_OPEN]}}); // R10 R11 R06
        end
        // Heat reports hold regardless of the command
        if (!auto_clear_mask[KIND_OT]) begin
            next_ot = live_ot | (channel_overtemp_constraint
                & {CHANNELS{~clr[KIND_OT]}}); // R10 R11
        end
        // On channels only: a held overload drops once switched off
        if (!auto_clear_mask[KIND_OC]) begin
            next_oc = live_oc | (channel_overcurrent_shutdown
                & commanded & {CHANNELS{~clr[KIND_OC]}}); // R10 R11 R04
        end
        // A clear while the die is still hot is undone at once
        if (!auto_clear_mask[KIND_SD]) begin
            next_sd = live_sd | (all_channel_overtemp_shutdown
                & ~clr[KIND_SD]); // R10 R11
        end
    end

    // Summary flags and per-kind activity
    always_comb begin
        // Summary covers held reports, so it stays while any report stays
        channel_summary_flag = channel_open_load_warning
            | channel_overtemp_constraint
            | channel_overcurrent_shutdown; // R14
        kind_any = {all_channel_overtemp_shutdown,
                    |channel_overcurrent_shutdown,
                    |channel_overtemp_constraint,
                    |channel_open_load_warning};
        // An event is a report that rises; a report kept alive across a
        // clear by its live cause is not seen as a new event
        kind_event = {next_sd & ~all_channel_overtemp_shutdown,
                      |(next_oc & ~channel_overcurrent_shutdown),
                      |(next_ot & ~channel_overtemp_constraint),
                      |(next_open & ~channel_open_load_warning)};
    end

    // Switch and clamp follow live faults, not held reports
    always_comb begin
        for (int i = 0; i < CHANNELS; i++) begin
            next_drive[i].switch_on = commanded[i] & ~live_ot[i]
                & ~live_oc[i] & ~live_sd; // R01 R02 R04
            // Low clamp shortens turn-off while the die is too hot
            next_drive[i].low_clamp = live_ot[i] | live_sd; // R01 R02
        end
        // Fault pin follows held reports so a brief fault is not missed
        // Pull-down enables: asserted means driving low
        next_fault_oe = |(kind_any & fault_select); // R09 R08
        next_open_oe = |channel_open_load_warning; // R05 R08
        next_irq = |(irq_status & irq_mask);
    end

    // Register writes; interrupt status set wins over write-one-to-clear
    always_comb begin
        next_auto = auto_clear_mask;
        next_fsel = fault_select;
        next_switch_enable_bits = switch_enable_bits;
        next_irq_mask = irq_mask;
        next_irq_status = irq_status | kind_event;
        if (wr_pend) begin
            case (addr_q)
                // Bit n commands channel n+1, ORed with its pin
                SWITCH_ENABLE_ADDR: next_switch_enable_bits = hwdata[CHANNELS-1:0];
                AUTO_CLEAR_ADDR: next_auto = hwdata[3:0];
                FAULT_SELECT_ADDR: next_fsel = hwdata[3:0]; // R09
                IRQ_MASK_ADDR: next_irq_mask = hwdata[3:0];
                // Set wins: an event in the clearing cycle keeps its bit
                IRQ_STATUS_ADDR: next_irq_status = kind_event
                    | (irq_status & ~hwdata[3:0]);
                default: ;
            endcase
        end
    end

    // Read mux, sampled from current state in the data phase
    always_comb begin
        rdata_c = 32'h0;
        case (addr_q)
            TOP_CHANNEL_DIAGNOSTIC_REGISTER_ADDR: begin
                rdata_c[TOP_SHUTDOWN_BIT] = all_channel_overtemp_shutdown; // R12
                rdata_c[CHANNELS-1:0] = channel_summary_flag; // R14
            end
            // Two channels share a word, lower channel in the low nibble
            CHANNEL_SUMMARY_FLAG_LO_ADDR, CHANNEL_SUMMARY_FLAG_HI_ADDR: begin
                for (int p = 0; p < 2; p++) begin
                    int c;
                    c = (addr_q == CHANNEL_SUMMARY_FLAG_HI_ADDR) ? p + 2 : p;
                    rdata_c[p*NIBBLE+OC_BIT] =
                        channel_overcurrent_shutdown[c]; // R13
                    rdata_c[p*NIBBLE+OT_BIT] =
                        channel_overtemp_constraint[c]; // R13
                    rdata_c[p*NIBBLE+OPEN_BIT] =
                        channel_open_load_warning[c]; // R13
                end
            end
            SWITCH_ENABLE_ADDR: rdata_c[CHANNELS-1:0] = switch_enable_bits;
            AUTO_CLEAR_ADDR: rdata_c[3:0] = auto_clear_mask;
            FAULT_SELECT_ADDR: rdata_c[3:0] = fault_select;
            IRQ_STATUS_ADDR: rdata_c[3:0] = irq_status;
            IRQ_MASK_ADDR: rdata_c[3:0] = irq_mask;
            // Real switch state, which differs from the command on a fault
            SWITCH_STATUS_ADDR: begin
                for (int s = 0; s < CHANNELS; s++) begin
                    rdata_c[s] = drive[s].switch_on;
                end
            end
            // Unmapped words read as zero
            default: rdata_c = 32'h0;
        endcase
        next_hrdata = rd_pend ? rdata_c : 32'h0;
    end

    // Bus state: writes finish with no wait; reads take one wait state
    // because the read word is registered before it reaches the bus
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            addr_q <= 12'h000;
        end else begin
            wr_pend <= bus_go && hwrite;
            rd_pend <= bus_go && !hwrite;
            // Address is held over the wait state and the data phase
            if (bus_go) begin
                addr_q <= {haddr[11:2], 2'b00};
            end
        end
    end

    // A read address phase pulls hreadyout low for one cycle; in that
    // cycle the word is registered, so it stands on hrdata at the edge
    // where the master next samples hready high. Writes never stall.
    logic next_wait; // Read address phase taken at this edge
    assign next_wait = bus_go && !hwrite;

    // Every report, software register and output of the block; outputs come
    // straight from here so the pins never see combinational glitches
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            channel_open_load_warning <= '0;
            channel_overtemp_constraint <= '0;
            channel_overcurrent_shutdown <= '0;
            all_channel_overtemp_shutdown <= 1'b0;
            auto_clear_mask <= AUTO_CLEAR_RESET;
            fault_select <= FAULT_SELECT_RESET;
            switch_enable_bits <= SWITCH_ENABLE_RESET;
            irq_status <= 4'h0;
            irq_mask <= IRQ_MASK_RESET;
            drive <= '0;
            fault_indicator_n_oe <= 1'b0;
            open_channel_indicator_n_oe <= 1'b0;
            fault_indicator_n_o <= 1'b0;
            open_channel_indicator_n_o <= 1'b0;
            irq <= 1'b0;
            hrdata <= 32'h0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            channel_open_load_warning <= next_open;
            channel_overtemp_constraint <= next_ot;
            channel_overcurrent_shutdown <= next_oc;
            all_channel_overtemp_shutdown <= next_sd;
            auto_clear_mask <= next_auto;
            fault_select <= next_fsel;
            switch_enable_bits <= next_switch_enable_bits;
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
            drive <= next_drive;
            fault_indicator_n_oe <= next_fault_oe; // R08
            open_channel_indicator_n_oe <= next_open_oe; // R08
            fault_indicator_n_o <= 1'b0;
            open_channel_indicator_n_o <= 1'b0;
            irq <= next_irq;
            hrdata <= next_hrdata;
            hreadyout <= !next_wait; // Low for the read wait state
            hresp <= 1'b0;
        end
    end
endmodule
`default_nettype wire
